// ===== ebcr_defines.vh
`ifndef EBCR_DEFINES_VH
`define EBCR_DEFINES_VH

`define EBCR_ADDR_MAG 8'h06
`define EBCR_ADDR_ROUTE 8'h07
`define EBCR_ADDR_BIAS 8'h08
`define EBCR_ADDR_SYSCTL 8'h09

`define EBCR_RST_MAG 8'h00
`define EBCR_RST_ROUTE 8'hff
`define EBCR_RST_BIAS 8'h00
`define EBCR_RST_SYSCTL 8'h10

`define EBCR_MAG_WMASK 8'hcf
`define EBCR_BIT_RAIL 7
`define EBCR_BIT_SWITCH 6
`define EBCR_BIT_LEVEL 7
`define EBCR_FULL_WMASK 8'hff
`define EBCR_MAG_CODE_MSB 3
`define EBCR_MAG_CODE_LSB 0
`define EBCR_ROUTE_TWO_MSB 7
`define EBCR_ROUTE_TWO_LSB 4
`define EBCR_ROUTE_ONE_MSB 3
`define EBCR_ROUTE_ONE_LSB 0
`define EBCR_BIAS_PINS_MSB 6
`define EBCR_BIAS_PINS_LSB 0

`define EBCR_CODE_DISC 4'hf
`define EBCR_CODE_COMMON 4'hc
`define EBCR_CODE_LAST_AIN 4'hb
`define EBCR_CODE_FIRST_WIDE 4'h8
`define EBCR_CODE_REF_POS 4'h6
`define EBCR_CODE_REF_NEG 4'h7

`endif

// ===== ebcr_reg8.v
`timescale 1ns/1ns
`default_nettype none
module ebcr_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK = 8'hff
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire wr_in,
  input wire [7:0] data_in,
  output reg [7:0] value_out
);
  // Bits outside the write mask hold their reset value forever.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      value_out <= RESET_VALUE;
    end else if (wr_in) begin
      value_out <= (data_in & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end
endmodule
`default_nettype wire

// ===== ebcr_route_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "ebcr_defines.vh"
module ebcr_route_decode (
  input wire [3:0] code_in,
  input wire six_input_in,
  output reg [12:0] pin_sel_out,
  output reg ref_pos_out,
  output reg ref_neg_out
);
  // One-hot pin select: bits 11:0 analog inputs, bit 12 common input.
  always @* begin
    pin_sel_out = 13'h0000;
    ref_pos_out = 1'b0;
    ref_neg_out = 1'b0;
    if (code_in == `EBCR_CODE_COMMON) begin
      pin_sel_out[12] = 1'b1; // see R7
    end else if (code_in <= `EBCR_CODE_LAST_AIN) begin
      if (six_input_in && code_in == `EBCR_CODE_REF_POS) begin
        ref_pos_out = 1'b1; // see R9
      end else if (six_input_in && code_in == `EBCR_CODE_REF_NEG) begin
        ref_neg_out = 1'b1; // see R9
      end else if (!(six_input_in && code_in >= `EBCR_CODE_FIRST_WIDE)) begin
        pin_sel_out[code_in] = 1'b1; // see R7
      end
    end
  end
endmodule
`default_nettype wire

// ===== ebcr_regs.v
// Contract
// R1: Magnitude bit 7 enables rail monitor.
// R2: Magnitude bit 6 closes low-side switch.
// R3: Power-down forces the switch open.
// R4: Magnitude bits 5:4 read zero, ignore writes.
// R5: Magnitude bits 3:0 select excitation current.
// R6: One magnitude drives both current sources.
// R7: Routing bits 7:4 route source two.
// R8: Routing bits 3:0 route source one.
// R9: Six-input codes 6,7 select second reference.
// R10: Routing register at 07h, reset ffh.
// R11: Bias bit 7 selects bias level.
// R12: Bias generator off with no pins.
// R13: Bias bits 6:0 connect common, inputs.
// R14: Any bias pin combination is allowed.
// R15: Bias register at 08h, reset 00h.
// R16: System control at 09h, reset 10h.
// R17: Magnitude register at 06h, reset 00h.
// R18: Software enables reference before current sources.
`timescale 1ns/1ns
`default_nettype none
`include "ebcr_defines.vh"
module ebcr_regs #(
  parameter SIX_INPUT = 0
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire power_down_in,
  output reg [7:0] rdata_out,
  output reg amp_rail_monitor_enable_out,
  output reg low_side_switch_close_out,
  output reg [3:0] source_one_magnitude_out,
  output reg [3:0] source_two_magnitude_out,
  output reg [12:0] source_one_pins_out,
  output reg [12:0] source_two_pins_out,
  output reg [1:0] source_one_ref_out,
  output reg [1:0] source_two_ref_out,
  output reg bias_level_select_out,
  output reg bias_generator_enable_out,
  output reg [6:0] bias_pins_out,
  output reg [7:0] system_control_out
);
  wire [7:0] mag_value;
  wire [7:0] route_value;
  wire [7:0] bias_value;
  wire [7:0] sys_value;
  wire [12:0] one_sel;
  wire [12:0] two_sel;
  wire one_rp;
  wire one_rn;
  wire two_rp;
  wire two_rn;
  wire wr_mag;
  wire wr_route;
  wire wr_bias;
  wire wr_sys;
  wire [3:0] route_one_code;
  wire [3:0] route_two_code;
  wire rail_bit;
  wire switch_bit;
  wire [3:0] mag_code;
  wire [7:0] mag_read;
  wire switch_close_next;
  wire level_bit;
  wire [6:0] bias_pin_bits;
  wire bias_any;
  reg pd_meta_reg;
  reg pd_sync_reg;
  reg [7:0] rdata_next;

  // Each register sees a write only when its own address is on the bus.
  assign wr_mag = wr_in && (addr_in == `EBCR_ADDR_MAG); // see R17
  assign wr_route = wr_in && (addr_in == `EBCR_ADDR_ROUTE); // see R10
  assign wr_bias = wr_in && (addr_in == `EBCR_ADDR_BIAS); // see R15
  assign wr_sys = wr_in && (addr_in == `EBCR_ADDR_SYSCTL); // see R16

  ebcr_reg8 #(.RESET_VALUE(`EBCR_RST_MAG), .WRITE_MASK(`EBCR_MAG_WMASK)) u_mag (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .wr_in(wr_mag), // see R4
    .data_in(wdata_in),
    .value_out(mag_value)
  );
  ebcr_reg8 #(.RESET_VALUE(`EBCR_RST_ROUTE), .WRITE_MASK(`EBCR_FULL_WMASK)) u_route (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .wr_in(wr_route),
    .data_in(wdata_in),
    .value_out(route_value)
  );
  ebcr_reg8 #(.RESET_VALUE(`EBCR_RST_BIAS), .WRITE_MASK(`EBCR_FULL_WMASK)) u_bias (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .wr_in(wr_bias),
    .data_in(wdata_in),
    .value_out(bias_value)
  );
  ebcr_reg8 #(.RESET_VALUE(`EBCR_RST_SYSCTL), .WRITE_MASK(`EBCR_FULL_WMASK)) u_sys (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .wr_in(wr_sys),
    .data_in(wdata_in),
    .value_out(sys_value)
  );

  // Field views of the stored registers.
  assign route_two_code = route_value[`EBCR_ROUTE_TWO_MSB:`EBCR_ROUTE_TWO_LSB]; // see R7
  assign route_one_code = route_value[`EBCR_ROUTE_ONE_MSB:`EBCR_ROUTE_ONE_LSB]; // see R8
  assign rail_bit = mag_value[`EBCR_BIT_RAIL]; // see R1
  assign switch_bit = mag_value[`EBCR_BIT_SWITCH]; // see R2
  assign mag_code = mag_value[`EBCR_MAG_CODE_MSB:`EBCR_MAG_CODE_LSB]; // see R5
  assign level_bit = bias_value[`EBCR_BIT_LEVEL]; // see R11
  assign bias_pin_bits = bias_value[`EBCR_BIAS_PINS_MSB:`EBCR_BIAS_PINS_LSB]; // see R13

  ebcr_route_decode u_dec_two (
    .code_in(route_two_code), // see R7
    .six_input_in(SIX_INPUT != 0),
    .pin_sel_out(two_sel),
    .ref_pos_out(two_rp),
    .ref_neg_out(two_rn)
  );
  ebcr_route_decode u_dec_one (
    .code_in(route_one_code), // see R8
    .six_input_in(SIX_INPUT != 0),
    .pin_sel_out(one_sel),
    .ref_pos_out(one_rp),
    .ref_neg_out(one_rn)
  );

  // Power-down comes from another part of the converter, so it passes two flip-flops first.
  // The price is latency: the switch opens on the third clock edge after power-down rises.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_meta_reg <= 1'b0;
    end else begin
      pd_meta_reg <= power_down_in;
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_sync_reg <= 1'b0;
    end else begin
      pd_sync_reg <= pd_meta_reg;
    end
  end

  // The switch may close only while the synchronised power-down level is low.
  assign switch_close_next = switch_bit && !pd_sync_reg; // see R2 see R3

  // The generator runs only while at least one pin takes the bias voltage.
  assign bias_any = |bias_pin_bits; // see R12

  // Reserved magnitude bits are masked again on the read path, so they read zero whatever the store holds.
  assign mag_read = mag_value & `EBCR_MAG_WMASK; // see R4

  // Unmapped addresses read as zero.
  always @* begin
    case (addr_in)
      `EBCR_ADDR_MAG: rdata_next = mag_read; // see R4
      `EBCR_ADDR_ROUTE: rdata_next = route_value;
      `EBCR_ADDR_BIAS: rdata_next = bias_value;
      `EBCR_ADDR_SYSCTL: rdata_next = sys_value;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stand for one cycle after the strobe and are zero otherwise, so an idle bus reads as zero.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      amp_rail_monitor_enable_out <= 1'b0;
    end else begin
      amp_rail_monitor_enable_out <= rail_bit; // see R1
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_side_switch_close_out <= 1'b0;
    end else begin
      low_side_switch_close_out <= switch_close_next; // see R2 see R3
    end
  end

  // Codes above the listed range pass on unchanged; the current sources decide what they mean.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_one_magnitude_out <= 4'h0;
    end else begin
      source_one_magnitude_out <= mag_code; // see R5 see R6
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_two_magnitude_out <= 4'h0;
    end else begin
      source_two_magnitude_out <= mag_code; // see R6
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_one_pins_out <= 13'h0000;
    end else begin
      source_one_pins_out <= one_sel; // see R8
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_two_pins_out <= 13'h0000;
    end else begin
      source_two_pins_out <= two_sel; // see R7
    end
  end

  // The reference selects can only rise on the six-input variant.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_one_ref_out <= 2'b00;
    end else begin
      source_one_ref_out <= {one_rn, one_rp}; // see R9
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_two_ref_out <= 2'b00;
    end else begin
      source_two_ref_out <= {two_rn, two_rp}; // see R9
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bias_level_select_out <= 1'b0;
    end else begin
      bias_level_select_out <= level_bit; // see R11
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bias_generator_enable_out <= 1'b0;
    end else begin
      bias_generator_enable_out <= bias_any; // see R12
    end
  end

  // Any mix of pins may take the bias at once; nothing here limits the count.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bias_pins_out <= 7'h00;
    end else begin
      bias_pins_out <= bias_pin_bits; // see R13 see R14
    end
  end

  // System control is only stored here for the rest of the converter; none of its fields act in this block.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      system_control_out <= `EBCR_RST_SYSCTL;
    end else begin
      system_control_out <= sys_value; // see R16
    end
  end
endmodule
`default_nettype wire

// ===== ebcr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ebcr_regs_chk #(parameter SIX_INPUT = 0) (
  input wire logic ref_clk_in, reset_in, wr_in, rd_in, power_down_in, low_side_switch_close_out,
  input wire logic bias_generator_enable_out,
  input wire logic [7:0] addr_in, wdata_in, rdata_out,
  input wire logic [3:0] source_one_magnitude_out, source_two_magnitude_out,
  input wire logic [12:0] source_one_pins_out, source_two_pins_out,
  input wire logic [6:0] bias_pins_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire w6 = wr_in && addr_in == 8'h06;
  wire w7 = wr_in && addr_in == 8'h07;
  a_sw_close: assert property ((!power_down_in)[*6] ##0 w6 && wdata_in[6] |-> ##2 low_side_switch_close_out)
    else $error("switch");
  a_pd_open: assert property (power_down_in[*4] |-> !low_side_switch_close_out)
    else $error("pd");
  a_resv_zero: assert property (rd_in && addr_in == 8'h06 |=> rdata_out[5:4] == 2'h0)
    else $error("resv");
  a_mag_follow: assert property (w6 |-> ##2 source_one_magnitude_out == $past(wdata_in[3:0], 2))
    else $error("mag");
  a_mag_shared: assert property (source_one_magnitude_out == source_two_magnitude_out)
    else $error("shared");
  a_route_one: assert property (w7 && wdata_in[3:0] < 4'hc |->
    ##2 source_one_pins_out == (SIX_INPUT != 0 && $past(wdata_in[3:0], 2) > 4'h5 ? 13'h0 :
    13'h1 << $past(wdata_in[3:0], 2))) else $error("route");
  a_route_off: assert property (w7 && wdata_in[7:4] > 4'hc |-> ##2 source_two_pins_out == 13'h0)
    else $error("off");
  a_bias_gen: assert property (bias_generator_enable_out == |bias_pins_out)
    else $error("gen");
  c_close: cover property (w6 && wdata_in[6]);
  c_pd: cover property (power_down_in[*4]);
  c_gen: cover property (bias_generator_enable_out);
endmodule
bind ebcr_regs ebcr_regs_chk #(.SIX_INPUT(SIX_INPUT)) chk (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .power_down_in(power_down_in),
  .low_side_switch_close_out(low_side_switch_close_out),
  .bias_generator_enable_out(bias_generator_enable_out),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .rdata_out(rdata_out),
  .source_one_magnitude_out(source_one_magnitude_out),
  .source_two_magnitude_out(source_two_magnitude_out),
  .source_one_pins_out(source_one_pins_out),
  .source_two_pins_out(source_two_pins_out),
  .bias_pins_out(bias_pins_out)
);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk_in = 1'h0, reset_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, pd = 1'h0, amp, sw, lvl, gen;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic [3:0] m1, m2;
  logic [12:0] p1, p2;
  logic [6:0] bp;
  logic [12:0] p1s, p2s;
  logic [1:0] r1, r2, r1s, r2s;
  logic [7:0] sc;
  int num_errors = 0, compares = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  ebcr_regs dut (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .power_down_in(pd), .rdata_out,
    .amp_rail_monitor_enable_out(amp), .low_side_switch_close_out(sw), .source_one_magnitude_out(m1),
    .source_two_magnitude_out(m2), .source_one_pins_out(p1), .source_two_pins_out(p2), .source_one_ref_out(r1),
    .source_two_ref_out(r2), .bias_level_select_out(lvl), .bias_generator_enable_out(gen), .bias_pins_out(bp),
    .system_control_out(sc));
  // The six-input variant shares every input so that the routing scenario covers both decodes.
  ebcr_regs #(.SIX_INPUT(1)) dut_six (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .power_down_in(pd), .rdata_out(), .amp_rail_monitor_enable_out(), .low_side_switch_close_out(),
    .source_one_magnitude_out(), .source_two_magnitude_out(), .source_one_pins_out(p1s), .source_two_pins_out(p2s),
    .source_one_ref_out(r1s), .source_two_ref_out(r2s), .bias_level_select_out(), .bias_generator_enable_out(),
    .bias_pins_out(), .system_control_out());
  task chk(input string n, input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, x, s);
    end
  endtask
  // Writes wait two extra edges because the decoded outputs trail the register by a cycle.
  task bus(input logic w, input logic [7:0] a, v);
    @(posedge ref_clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= v;
    @(posedge ref_clk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    if (w) repeat (2) @(posedge ref_clk_in);
    #1;
    if (!w) chk("rdata", rdata_out, v);
  endtask
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task t_mag;
    for (int c = 0; c < 7; c++) begin
      bus(1'h1, 8'h06, {4'hc, c[3:0]});
      chk("mag", {amp, sw, m2, m1}, {2'h3, c[3:0], c[3:0]});
    end
    bus(1'h0, 8'h06, 8'hc6);
    @(posedge ref_clk_in);
    pd <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
    #1 chk("pd", sw, 1'h0);
    @(posedge ref_clk_in);
    pd <= 1'h0;
    bus(1'h1, 8'h06, 8'h40);
    chk("mag", {amp, sw}, 2'h1);
  endtask
  task t_route;
    logic [12:0] e, f;
    for (int c = 0; c < 16; c++) begin
      e = c < 12 ? 13'h1 << c : {c == 12, 12'h0};
      f = c < 6 ? e : {c == 12, 12'h0};
      bus(1'h1, 8'h07, {c[3:0], c[3:0]});
      chk("route", {r2, r1, p2, p1}, {4'h0, e, e});
      chk("route6", {r2s, r1s, p2s, p1s}, {c == 7, c == 6, c == 7, c == 6, f, f});
    end
  endtask
  task t_bias;
    for (int i = 0; i < 7; i++) begin
      bus(1'h1, 8'h08, 8'h80 | 8'h1 << i);
      chk("bias", {lvl, gen, bp}, {2'h3, 7'h1 << i});
    end
    bus(1'h1, 8'h08, 8'h7f);
    chk("bias", {lvl, gen, bp}, 9'h0ff);
    bus(1'h1, 8'h08, 8'h00);
    chk("bias", gen, 1'h0);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'h0;
    for (int a = 6; a < 11; a++)
      bus(1'h0, a[7:0], a == 7 ? 8'hff : a == 9 ? 8'h10 : 8'h00);
    chk("sysctl", sc, 8'h10);
    // The reference enable lives outside this block; the bench treats it as on before any current is set.
    t_mag;
    t_route;
    t_bias;
    bus(1'h1, 8'h09, 8'h5a);
    chk("sysctl", sc, 8'h5a);
    bus(1'h0, 8'h09, 8'h5a);
    summarize;
  end
endmodule
`default_nettype wire
